// ### verilog/imcc_pkg.sv
// Constants for the interrupt mask clear and configuration register bank
package imcc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned VEC_N = 32;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_MASK_SET = 12'h00c;
    localparam logic [11:0] OFF_UNMASK = 12'h010;
    localparam logic [11:0] OFF_CONFIG = 12'h014;

    // ==========================================================
    // Configuration field positions
    localparam int unsigned CQES_LSB = 20;
    localparam int unsigned CQES_MSB = 23;
    localparam int unsigned SQES_LSB = 16;
    localparam int unsigned SQES_MSB = 19;
    localparam int unsigned RSVD_LSB = 24;
    localparam int unsigned RSVD_MSB = 31;
    localparam int unsigned ES_W = 4;

    // ==========================================================
    // Reset values
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [3:0] CQES_RST = 4'h0;
    localparam logic [3:0] SQES_RST = 4'h0;

    // ==========================================================
    // Bus answer state
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RESP = 1'b1
    } imcc_state_e;

endpackage : imcc_pkg

// ### verilog/imcc_rst_sync.sv
// Reset release synchroniser for the register bank
module imcc_rst_sync (
    // Clock and raw reset
    input wire logic core_clk,
    input wire logic nrst,
    // Synchronised reset
    output logic rst_sync_n
);

    logic meta_q;
    logic hold_q;

    // Assert at once, release after two edges
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            hold_q <= meta_q;
        end
    end

    assign rst_sync_n = hold_q;

endmodule : imcc_rst_sync

// ### verilog/imcc_mask_bank.sv
// Per-vector interrupt mask state shared by the set and clear registers
module imcc_mask_bank (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Write strobes, one bit per vector
    input wire logic [31:0] set_bits,
    input wire logic [31:0] clr_bits,
    // Current mask, one means masked
    output logic [31:0] mask_q
);

    logic [31:0] mask_d;

    // ==========================================================
    // One cell per vector
    genvar gi;
    generate
        for (gi = 0; gi < imcc_pkg::VEC_N; gi++) begin : g_vec
            // Set and clear never meet: one bus write per transfer
            always_comb begin
                if (set_bits[gi]) begin
                    mask_d[gi] = 1'b1;
                end else if (clr_bits[gi]) begin
                    mask_d[gi] = 1'b0;
                end else begin
                    mask_d[gi] = mask_q[gi];
                end
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mask_q[gi] <= imcc_pkg::MASK_RST[gi];
                end else begin
                    mask_q[gi] <= mask_d[gi];
                end
            end
        end
    endgenerate

endmodule : imcc_mask_bank

// ### verilog/imcc_top.sv
// APB register bank: interrupt vector mask set/clear and queue entry sizes
//
// Notes on behaviour
// - The unmask register exists for pin, single MSI and multi MSI use.
// - Writing one to an unmask bit clears that vector's mask.
// - Writing zero to an unmask bit leaves that vector's mask alone.
// - Reading the unmask register returns the live mask, one = masked.
// - Config bits 23:20 hold the completion entry size, reset zero.
// - Config bits 19:16 hold the submission entry size, reset zero.
// - Writing one to a mask-set bit masks that vector in the same mask.
//
// The implementer's own choice: the APB slave port.
module imcc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller state
    output logic [31:0] irq_mask,
    output logic [3:0] completion_entry_size,
    output logic [3:0] submission_entry_size
);

    // ==========================================================
    // Reset
    logic rst_n;

    imcc_rst_sync u_rst (
        .core_clk(core_clk),
        .nrst(nrst),
        .rst_sync_n(rst_n)
    );

    // ==========================================================
    // Address decode
    logic hit_set;
    logic hit_unmask;
    logic hit_cfg;
    logic hit_any;
    logic wr_commit;

    assign hit_set = (paddr == imcc_pkg::OFF_MASK_SET);
    assign hit_unmask = (paddr == imcc_pkg::OFF_UNMASK);
    assign hit_cfg = (paddr == imcc_pkg::OFF_CONFIG);
    // Full-word compare: any other offset answers with an error
    assign hit_any = hit_set | hit_unmask | hit_cfg;
    // Writes land only on the edge that completes the transfer
    assign wr_commit = psel & penable & pwrite & pready;

    // ==========================================================
    // Mask state
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] mask_q;

    // Both strobes feed one shared mask, so the two reads agree
    assign set_bits = (wr_commit && hit_set) ? pwdata : '0;
    assign clr_bits = (wr_commit && hit_unmask) ? pwdata : '0;

    imcc_mask_bank u_mask (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set_bits(set_bits),
        .clr_bits(clr_bits),
        .mask_q(mask_q)
    );

    assign irq_mask = mask_q;

    // ==========================================================
    // Configuration fields
    logic [3:0] cqes_d;
    logic [3:0] cqes_q;
    logic [3:0] sqes_d;
    logic [3:0] sqes_q;

    // Only the size fields are stored; the rest of the word is wiring
    always_comb begin
        cqes_d = cqes_q;
        sqes_d = sqes_q;
        if (wr_commit && hit_cfg) begin
            cqes_d = pwdata[imcc_pkg::CQES_MSB:imcc_pkg::CQES_LSB];
            sqes_d = pwdata[imcc_pkg::SQES_MSB:imcc_pkg::SQES_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cqes_q <= imcc_pkg::CQES_RST;
            sqes_q <= imcc_pkg::SQES_RST;
        end else begin
            cqes_q <= cqes_d;
            sqes_q <= sqes_d;
        end
    end

    assign completion_entry_size = cqes_q;
    assign submission_entry_size = sqes_q;

    // ==========================================================
    // Bus answer: one wait state, registered read data
    imcc_pkg::imcc_state_e st_d;
    imcc_pkg::imcc_state_e st_q;
    logic ready_d;
    logic ready_q;
    logic err_d;
    logic err_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [31:0] cfg_view;

    // Upper byte and unlaid fields are never stored
    always_comb begin
        cfg_view = '0;
        cfg_view[imcc_pkg::CQES_MSB:imcc_pkg::CQES_LSB] = cqes_q;
        cfg_view[imcc_pkg::SQES_MSB:imcc_pkg::SQES_LSB] = sqes_q;
    end

    always_comb begin
        st_d = st_q;
        ready_d = 1'b0;
        err_d = 1'b0;
        rdata_d = rdata_q;
        case (st_q)
            imcc_pkg::ST_IDLE: begin
                if (psel && penable) begin
                    st_d = imcc_pkg::ST_RESP;
                    ready_d = 1'b1;
                    err_d = ~hit_any;
                    rdata_d = '0;
                    if (!pwrite) begin
                        // Both mask registers read the live mask
                        if (hit_set || hit_unmask) begin
                            rdata_d = mask_q;
                        end else if (hit_cfg) begin
                            rdata_d = cfg_view;
                        end
                    end
                end
            end
            imcc_pkg::ST_RESP: begin
                st_d = imcc_pkg::ST_IDLE;
            end
            default: begin
                st_d = imcc_pkg::ST_IDLE;
            end
        endcase
    end

    // Registered answer costs a cycle but keeps the bus outputs clean
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= imcc_pkg::ST_IDLE;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            st_q <= st_d;
            ready_q <= ready_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    assign pready = ready_q;
    assign pslverr = err_q;
    assign prdata = rdata_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic rd_done;
    assign rd_done = psel & penable & ~pwrite & pready;

    a_unmask_mapped: assert property (
        (rd_done || wr_commit) && hit_unmask |-> !pslverr)
        else $error("unmask register answered with an error");

    a_unmask_clears: assert property (
        wr_commit && hit_unmask |=> (irq_mask & $past(pwdata)) == '0)
        else $error("written one did not unmask the vector");

    a_zero_keeps: assert property (
        wr_commit && hit_unmask
        |=> (irq_mask & ~$past(pwdata)) == ($past(irq_mask) & ~$past(pwdata)))
        else $error("zero bit changed the mask");

    a_read_live_mask: assert property (
        rd_done && hit_unmask |-> prdata == irq_mask)
        else $error("unmask read did not return the live mask");

    a_cq_size_store: assert property (
        wr_commit && hit_cfg
        |=> completion_entry_size == $past(pwdata[23:20]))
        else $error("completion entry size not stored");

    a_sq_size_store: assert property (
        wr_commit && hit_cfg
        |=> submission_entry_size == $past(pwdata[19:16]))
        else $error("submission entry size not stored");

    a_mask_set_bits: assert property (
        wr_commit && hit_set
        |=> (irq_mask & $past(pwdata)) == $past(pwdata)
            && (irq_mask & ~$past(pwdata))
               == ($past(irq_mask) & ~$past(pwdata)))
        else $error("mask set write did not mask the vector");

    a_rsvd_zero: assert property (
        rd_done && hit_cfg |-> prdata[31:24] == 8'h00)
        else $error("reserved configuration byte not zero");

    a_answer_bound: assert property (
        psel && penable && !pready |-> ##1 pready)
        else $error("access not answered in one wait state");

    // ==========================================================
    // Bus protocol checks
    // Fixed single wait state: masters may count on it
    a_wait_state: assert property (
        $rose(psel && penable) |-> !pready)
        else $error("first access cycle already answered");

    a_ready_needs_access: assert property (
        !(psel && penable) |=> !pready)
        else $error("ready raised without an access phase");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    a_err_needs_ready: assert property (
        pslverr |-> pready)
        else $error("error flag raised outside a completion");

    a_err_on_unmapped: assert property (
        (rd_done || wr_commit) |-> pslverr == !hit_any)
        else $error("error flag does not match the decode");

    a_bad_read_zero: assert property (
        rd_done && !hit_any |-> prdata == '0)
        else $error("unmapped read returned data");

    // ==========================================================
    // Mask and configuration state checks
    // Quiet checks catch stray enables that the write checks miss
    a_mask_quiet: assert property (
        !(wr_commit && (hit_set || hit_unmask)) |=> $stable(irq_mask))
        else $error("mask moved without a mask write");

    a_unmask_only_clears: assert property (
        wr_commit && hit_unmask |=> (irq_mask & ~$past(irq_mask)) == '0)
        else $error("unmask write masked a vector");

    a_set_read_mask: assert property (
        rd_done && hit_set |-> prdata == irq_mask)
        else $error("mask set read did not return the live mask");

    a_cq_size_quiet: assert property (
        !(wr_commit && hit_cfg) |=> $stable(completion_entry_size))
        else $error("completion entry size moved without a write");

    a_sq_size_quiet: assert property (
        !(wr_commit && hit_cfg) |=> $stable(submission_entry_size))
        else $error("submission entry size moved without a write");

    a_cfg_read_view: assert property (
        rd_done && hit_cfg
        |-> prdata == {8'h00, completion_entry_size, submission_entry_size,
                       16'h0000})
        else $error("configuration read does not match the stored sizes");

    a_bad_write_quiet: assert property (
        wr_commit && !hit_any
        |=> $stable(irq_mask) && $stable(completion_entry_size)
            && $stable(submission_entry_size))
        else $error("unmapped write changed stored state");

    a_read_keeps_state: assert property (
        rd_done
        |=> $stable(irq_mask) && $stable(completion_entry_size)
            && $stable(submission_entry_size))
        else $error("read changed the stored state");

    // ==========================================================
    // Scenarios worth seeing
    c_unmask_write: cover property (wr_commit && hit_unmask);
    c_set_then_clear: cover property (
        wr_commit && hit_set ##[1:20] wr_commit && hit_unmask);
    c_cfg_read: cover property (rd_done && hit_cfg);
    c_bad_addr: cover property (pready && pslverr);
    c_mask_read: cover property (rd_done && hit_set);

endmodule : imcc_top

// ### tb/testbench.sv
// Self-checking bench for the interrupt mask and configuration bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset and bus signals
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] irq_mask;
    logic [3:0] completion_entry_size;
    logic [3:0] submission_entry_size;
    int err_count = 0;
    int compares = 0;
    // Bench copy of the live mask and the two entry sizes
    logic [31:0] mask_m = 32'h0000_0000;
    logic [3:0] cqes_m = 4'h0;
    logic [3:0] sqes_m = 4'h0;
    // Last entry is unmapped, so random traffic also hits the error path
    logic [11:0] addr_tab [4] = '{12'h00c, 12'h010, 12'h014, 12'h018};

    always #12.5 core_clk = ~core_clk;

    imcc_top imcc_top_i (
        .core_clk(core_clk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq_mask(irq_mask),
        .completion_entry_size(completion_entry_size),
        .submission_entry_size(submission_entry_size)
    );

    // ==========================================================
    // Expectations
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == imcc_pkg::OFF_MASK_SET) ||
            (a == imcc_pkg::OFF_UNMASK) || (a == imcc_pkg::OFF_CONFIG);
    endfunction : mapped

    function automatic logic [31:0] exp_read(input logic [11:0] a);
        if (a == imcc_pkg::OFF_MASK_SET || a == imcc_pkg::OFF_UNMASK) begin
            exp_read = mask_m;
        end else if (a == imcc_pkg::OFF_CONFIG) begin
            exp_read = {8'h00, cqes_m, sqes_m, 16'h0000};
        end else begin
            exp_read = 32'h0000_0000;
        end
    endfunction : exp_read

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // One APB transfer, then compare against the bench model
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        int n;
        // Leading edge keeps psel from being driven twice in one step
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            err_count++;
            $display("wrong value at %0t: no pready", $time);
        end
        chk({31'h0, err}, {31'h0, !mapped(a)});
        if (!wr) begin
            chk(rd, exp_read(a));
        end else if (a == imcc_pkg::OFF_MASK_SET) begin
            mask_m = mask_m | d;
        end else if (a == imcc_pkg::OFF_UNMASK) begin
            mask_m = mask_m & ~d;
        end else if (a == imcc_pkg::OFF_CONFIG) begin
            cqes_m = d[23:20];
            sqes_m = d[19:16];
        end
        // Let the write edge settle before looking at the level outputs
        #1;
        chk(irq_mask, mask_m);
        chk({28'h0, completion_entry_size}, {28'h0, cqes_m});
        chk({28'h0, submission_entry_size}, {28'h0, sqes_m});
    endtask : xfer

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hb509));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        xfer(1'b0, imcc_pkg::OFF_UNMASK, 32'h0000_0000);
        xfer(1'b0, imcc_pkg::OFF_CONFIG, 32'h0000_0000);
        xfer(1'b1, imcc_pkg::OFF_MASK_SET, 32'hffff_ffff);
        // No MSI-X mode here, so the unmask register is fair game
        xfer(1'b1, imcc_pkg::OFF_UNMASK, 32'h0000_0000);
        xfer(1'b0, imcc_pkg::OFF_UNMASK, 32'h0000_0000);
        xfer(1'b1, imcc_pkg::OFF_UNMASK, 32'h8000_0001);
        xfer(1'b0, imcc_pkg::OFF_MASK_SET, 32'h0000_0000);
        xfer(1'b1, imcc_pkg::OFF_CONFIG, 32'hffff_ffff);
        xfer(1'b0, imcc_pkg::OFF_CONFIG, 32'h0000_0000);
        xfer(1'b1, imcc_pkg::OFF_CONFIG, 32'h00a5_0000);
        xfer(1'b1, 12'h018, 32'hffff_ffff);
        xfer(1'b0, 12'h018, 32'h0000_0000);
        // Mid-run reset must drop every stored value back to its default
        @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        #1;
        mask_m = imcc_pkg::MASK_RST;
        cqes_m = imcc_pkg::CQES_RST;
        sqes_m = imcc_pkg::SQES_RST;
        chk(irq_mask, mask_m);
        chk({28'h0, completion_entry_size}, {28'h0, cqes_m});
        chk({28'h0, submission_entry_size}, {28'h0, sqes_m});
        @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        xfer(1'b0, imcc_pkg::OFF_UNMASK, 32'h0000_0000);
        xfer(1'b0, imcc_pkg::OFF_CONFIG, 32'h0000_0000);
        repeat (300) begin
            xfer(1'($urandom_range(1)), addr_tab[$urandom_range(3)],
                $urandom());
        end
        report_and_stop();
    end

    // Runs out well after the ~1300 cycles the sequence needs
    initial begin
        repeat (8000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end

endmodule : testbench
